// [rtl/dtg_deadtime.sv]
// dead-time generators and pair-mode output steering
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
module dtg_deadtime import dtg_pkg::*; (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire dtg_bus_s bus_in,
   input wire logic [NUM_PAIRS-1:0] duty_cmp_in,
   input wire logic [NUM_PAIRS*2-1:0] duty_lsb_in,
   output dtg_rsp_s rsp_out,
   output logic [NUM_PINS-1:0] pwm_out,
   output dtg_phase_e phase_out
);
// Notes on behaviour
// - divide select bits 7-6: 11 /16, 10 /8, 01 /4, 00 /2
// - low six config bits give dead-time count loaded into down counter
// - prescaler clears on counter load, config write and reset
// - divide /4 /8 /16 with timebase prescale not 1:1 counts on phase one
// - timebase 1:1 with divide /2 counts on two phases per cycle
// - match on phase one or three uses one and three, else two and four
// - divide /4 /8 /16 with timebase 1:1 counts on the match phase
// - dead time equals count times divisor over oscillator rate
// - dead time at or above duty keeps both pair outputs inactive
// - pair-mode select bit set puts pair in independent mode
// - independent mode inserts no dead time, both pins may be active
// - compare n drives pins 2n+1 and 2n in independent mode
// - each independent pin selects pwm, forced inactive or forced active
// - each pair has a six-bit counter reloaded on every compare edge
// - turn-on of the rising pin waits for counter to reach zero
// - cleared select bit means complementary mode, default after reset

   logic [DATA_W-1:0] dt_cfg_ff;
   logic [DATA_W-1:0] pair_cfg_ff;
   logic [DATA_W-1:0] ovd_en_ff;
   logic [DATA_W-1:0] ovd_st_ff;
   logic [DATA_W-1:0] tb_ctrl_ff;
   logic [DATA_W-1:0] nxt_rdata;
   logic [DATA_W-1:0] rdata_ff;
   logic [3:0] pre_ff;
   logic [3:0] pre_mask;
   logic pre_tick;
   logic [NUM_PAIRS-1:0] cmp_d_ff;
   logic [NUM_PAIRS-1:0] edge_evt;
   logic [NUM_PAIRS-1:0] odd_ff;
   logic [NUM_PAIRS-1:0] even_ff;
   logic [NUM_PAIRS-1:0] busy;
   logic [CNT_W-1:0] cnt_ff [NUM_PAIRS];
   logic [NUM_PAIRS-1:0] pair_ph_odd_ff;
   logic [3:0] match_ph_ff [NUM_PAIRS];
   logic [NUM_PINS-1:0] raw_pin;
   logic [NUM_PINS-1:0] nxt_pwm;
   logic cfg_wr;
   logic tb_1to1;
   logic [1:0] div_sel;
   dtg_phase_e phase_ff;

   assign cfg_wr = bus_in.wr && (bus_in.addr == ADDR_DEADTIME_CONFIG);
   assign div_sel = dt_cfg_ff[DIV_MSB:DIV_LSB];
   assign tb_1to1 = (tb_ctrl_ff[TB_RUN_BIT-1:0] == TB_PRESCALE_1TO1);

   // four-phase instruction cycle
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         phase_ff <= PH_ONE;
      end else begin
         case (phase_ff)
            PH_ONE: phase_ff <= PH_TWO;
            PH_TWO: phase_ff <= PH_THREE;
            PH_THREE: phase_ff <= PH_FOUR;
            PH_FOUR: phase_ff <= PH_ONE;
            default: phase_ff <= PH_ONE;
         endcase
      end
   end
   assign phase_out = phase_ff;

   // register file
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         dt_cfg_ff <= DEADTIME_CONFIG_RST;
         pair_cfg_ff <= OUTPUT_PAIR_CONFIG_RST;
         ovd_en_ff <= OVERRIDE_ENABLE_MASK_RST;
         ovd_st_ff <= OVERRIDE_STATE_RST;
         tb_ctrl_ff <= TIMEBASE_CTRL_RST;
      end else if (bus_in.wr) begin
         case (bus_in.addr)
            ADDR_DEADTIME_CONFIG: dt_cfg_ff <= bus_in.wdata;
            ADDR_OUTPUT_PAIR_CONFIG: pair_cfg_ff <= {5'h00, bus_in.wdata[NUM_PAIRS-1:0]};
            ADDR_OVERRIDE_ENABLE_MASK: ovd_en_ff <= {2'h0, bus_in.wdata[NUM_PINS-1:0]};
            ADDR_OVERRIDE_STATE: ovd_st_ff <= {2'h0, bus_in.wdata[NUM_PINS-1:0]};
            ADDR_TIMEBASE_CTRL: tb_ctrl_ff <= {5'h00, bus_in.wdata[TB_RUN_BIT:0]};
            default: ;
         endcase
      end
   end

   always_comb begin
      case (bus_in.addr)
         ADDR_DEADTIME_CONFIG: nxt_rdata = dt_cfg_ff;
         ADDR_OUTPUT_PAIR_CONFIG: nxt_rdata = pair_cfg_ff;
         ADDR_OVERRIDE_ENABLE_MASK: nxt_rdata = ovd_en_ff;
         ADDR_OVERRIDE_STATE: nxt_rdata = ovd_st_ff;
         ADDR_TIMEBASE_CTRL: nxt_rdata = tb_ctrl_ff;
         ADDR_STATUS: nxt_rdata = {2'h0, busy[2], busy[1], busy[0], 3'h0};
         default: nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= bus_in.rd ? nxt_rdata : 8'h00;
      end
   end
   assign rsp_out.rdata = rdata_ff;

   // shared prescaler; clearing it on each load and config write gives count times divisor
   always_comb begin
      case (div_sel)
         DIV_4: pre_mask = PRE_MASK_4;
         DIV_8: pre_mask = PRE_MASK_8;
         DIV_16: pre_mask = PRE_MASK_16;
         // divide-by-2 ticks come from the phase pair, mask unused there
         default: pre_mask = PRE_MASK_4;
      endcase
   end
   // low two bits span one instruction cycle, which holds exactly one gating
   // phase; ignoring them keeps ticks on that phase whatever the clear point
   assign pre_tick = (((pre_ff | PRE_MASK_4) & pre_mask) == pre_mask);

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in || cfg_wr || (|edge_evt)) begin
         pre_ff <= PRE_ZERO;
      end else begin
         pre_ff <= pre_ff + 4'h1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         cmp_d_ff <= '0;
      end else begin
         cmp_d_ff <= duty_cmp_in;
      end
   end
   assign edge_evt = cmp_d_ff ^ duty_cmp_in;

   genvar g;
   generate
      for (g = 0; g < NUM_PAIRS; g++) begin : g_pair
         logic dec_en;
         logic ph_ok;
         logic [1:0] lsb;
         assign lsb = duty_lsb_in[2*g+1:2*g];
         always_comb begin
            // /2 outside 1:1 keeps the phase pair so the tick rate still holds
            if (div_sel == DIV_2) begin
               ph_ok = pair_ph_odd_ff[g] ? (phase_ff == PH_ONE || phase_ff == PH_THREE)
                                         : (phase_ff == PH_TWO || phase_ff == PH_FOUR);
            end else if (tb_1to1) begin
               ph_ok = (phase_ff == dtg_phase_e'(match_ph_ff[g]));
            end else begin
               ph_ok = (phase_ff == PH_ONE);
            end
         end
         // divide-by-2 ticks are built from the phase pair itself
         assign dec_en = ph_ok && (div_sel == DIV_2 ? 1'b1 : pre_tick);
         assign busy[g] = (cnt_ff[g] != CNT_ZERO);

         always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
               cnt_ff[g] <= CNT_ZERO;
               pair_ph_odd_ff[g] <= 1'b1;
               match_ph_ff[g] <= PH_ONE;
            end else if (edge_evt[g]) begin
               cnt_ff[g] <= dt_cfg_ff[CNT_MSB:0];
               pair_ph_odd_ff[g] <= ~lsb[0];
               match_ph_ff[g] <= 4'h1 << lsb;
            end else if (busy[g] && dec_en) begin
               cnt_ff[g] <= cnt_ff[g] - 6'h01;
            end
         end

         // pulse shorter than dead time reloads before expiry: both stay off
         always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
               odd_ff[g] <= 1'b0;
               even_ff[g] <= 1'b0;
            end else if (edge_evt[g]) begin
               odd_ff[g] <= 1'b0;
               even_ff[g] <= 1'b0;
            end else if (!busy[g]) begin
               odd_ff[g] <= cmp_d_ff[g];
               even_ff[g] <= ~cmp_d_ff[g];
            end
         end

         always_comb begin
            if (pair_cfg_ff[g]) begin
               raw_pin[2*g+1] = duty_cmp_in[g];
               raw_pin[2*g] = duty_cmp_in[g];
            end else begin
               raw_pin[2*g+1] = odd_ff[g];
               raw_pin[2*g] = even_ff[g] && !odd_ff[g];
            end
         end
      end
   endgenerate

   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         nxt_pwm[i] = ovd_en_ff[i] ? raw_pin[i] : ovd_st_ff[i];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         pwm_out <= '0;
      end else begin
         pwm_out <= nxt_pwm;
      end
   end

   // counter checks watch pair 0, steering checks also pairs 1 and 2; the other pairs share the generate code
   property p_load;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      edge_evt[0] |=> cnt_ff[0] == $past(dt_cfg_ff[CNT_MSB:0]);
   endproperty
   a_load: assert property (p_load) else $error("counter not loaded");
   property p_pre_clr;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      cfg_wr |=> pre_ff == PRE_ZERO;
   endproperty
   a_pre_clr: assert property (p_pre_clr) else $error("prescaler not cleared");
   property p_edge_clr;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (|edge_evt) |=> pre_ff == PRE_ZERO;
   endproperty
   a_edge_clr: assert property (p_edge_clr) else $error("prescaler kept on load");
   property p_ph1;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (busy[0] && !edge_evt[0] && !tb_1to1 && div_sel != DIV_2 && phase_ff != PH_ONE)
         |=> cnt_ff[0] == $past(cnt_ff[0]);
   endproperty
   a_ph1: assert property (p_ph1) else $error("decrement off phase one");
   property p_pair_rate;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (busy[0] && !edge_evt[0] && div_sel == DIV_2 && tb_1to1 && (pair_ph_odd_ff[0]
         ? (phase_ff == PH_ONE || phase_ff == PH_THREE)
         : (phase_ff == PH_TWO || phase_ff == PH_FOUR)))
         |=> cnt_ff[0] == $past(cnt_ff[0]) - 6'h01;
   endproperty
   a_pair_rate: assert property (p_pair_rate) else $error("phase pair tick missed");
   property p_pair_skip;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (busy[0] && !edge_evt[0] && div_sel == DIV_2 && pair_ph_odd_ff[0]
         && (phase_ff == PH_TWO || phase_ff == PH_FOUR)) |=> cnt_ff[0] == $past(cnt_ff[0]);
   endproperty
   a_pair_skip: assert property (p_pair_skip) else $error("tick off the phase pair");
   property p_match_ph;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (busy[0] && !edge_evt[0] && tb_1to1 && div_sel != DIV_2
         && phase_ff != dtg_phase_e'(match_ph_ff[0])) |=> cnt_ff[0] == $past(cnt_ff[0]);
   endproperty
   a_match_ph: assert property (p_match_ph) else $error("decrement off match phase");
   property p_phase;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      phase_ff == PH_ONE |=> phase_ff == PH_TWO
         ##1 phase_ff == PH_THREE ##1 phase_ff == PH_FOUR;
   endproperty
   a_phase: assert property (p_phase) else $error("phase order wrong");
   property p_hold;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (!pair_cfg_ff[0] && busy[0]) |=> !odd_ff[0] && !even_ff[0];
   endproperty
   a_hold: assert property (p_hold) else $error("output on during dead time");
   property p_nonover;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (!pair_cfg_ff[0] && ovd_en_ff[1:0] == 2'h3) |=> !(pwm_out[1] && pwm_out[0]);
   endproperty
   a_nonover: assert property (p_nonover) else $error("pair overlap");
   property p_indep;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (pair_cfg_ff[1] && ovd_en_ff[3:2] == 2'h3) |=> pwm_out[3] == $past(duty_cmp_in[1])
         && pwm_out[2] == $past(duty_cmp_in[1]);
   endproperty
   a_indep: assert property (p_indep) else $error("independent steering wrong");
   property p_indep_both;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (pair_cfg_ff[2] && ovd_en_ff[5:4] == 2'h3 && duty_cmp_in[2])
         |=> pwm_out[5] && pwm_out[4];
   endproperty
   a_indep_both: assert property (p_indep_both) else $error("pins not both on");
   property p_ovd;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      !ovd_en_ff[5] |=> pwm_out[5] == $past(ovd_st_ff[5]);
   endproperty
   a_ovd: assert property (p_ovd) else $error("override ignored");
   property p_rst_mode;
      @(posedge sys_clk_in)
      !rst_n_in |=> pair_cfg_ff == OUTPUT_PAIR_CONFIG_RST && pwm_out == '0;
   endproperty
   a_rst_mode: assert property (p_rst_mode) else $error("pair mode not reset");
   c_load: cover property (@(posedge sys_clk_in) edge_evt[0] && dt_cfg_ff[CNT_MSB:0] != CNT_ZERO);
   c_expire: cover property (@(posedge sys_clk_in) busy[0] ##1 !busy[0]);
   c_indep: cover property (@(posedge sys_clk_in) pair_cfg_ff[2] && pwm_out[5] && pwm_out[4]);
   c_pair: cover property (@(posedge sys_clk_in) div_sel == DIV_2 && tb_1to1 && busy[0]);
endmodule

// [rtl/dtg_pkg.sv]
// package for the pwm dead-time and pair-mode block
package dtg_pkg;
   localparam int NUM_PAIRS = 3;
   localparam int NUM_PINS = 6;
   localparam int CNT_W = 6;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_DEADTIME_CONFIG = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_OUTPUT_PAIR_CONFIG = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_OVERRIDE_ENABLE_MASK = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_OVERRIDE_STATE = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_TIMEBASE_CTRL = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h5;
   localparam logic [DATA_W-1:0] DEADTIME_CONFIG_RST = 8'h00;
   localparam logic [DATA_W-1:0] OUTPUT_PAIR_CONFIG_RST = 8'h00;
   localparam logic [DATA_W-1:0] OVERRIDE_ENABLE_MASK_RST = 8'h3F;
   localparam logic [DATA_W-1:0] OVERRIDE_STATE_RST = 8'h00;
   localparam logic [DATA_W-1:0] TIMEBASE_CTRL_RST = 8'h00;
   localparam int DIV_MSB = 7;
   localparam int DIV_LSB = 6;
   localparam int CNT_MSB = 5;
   localparam int TB_RUN_BIT = 2;
   localparam logic [1:0] DIV_2 = 2'h0;
   localparam logic [1:0] DIV_4 = 2'h1;
   localparam logic [1:0] DIV_8 = 2'h2;
   localparam logic [1:0] DIV_16 = 2'h3;
   localparam logic [1:0] TB_PRESCALE_1TO1 = 2'h0;
   localparam logic [3:0] PRE_MASK_4 = 4'h3;
   localparam logic [3:0] PRE_MASK_8 = 4'h7;
   localparam logic [3:0] PRE_MASK_16 = 4'hF;
   localparam logic [3:0] PRE_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
   typedef enum logic [3:0] {
      PH_ONE = 4'b0001,
      PH_TWO = 4'b0010,
      PH_THREE = 4'b0100,
      PH_FOUR = 4'b1000
   } dtg_phase_e;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } dtg_bus_s;
   typedef struct packed {
      logic [DATA_W-1:0] rdata;
   } dtg_rsp_s;
endpackage

// [bench/dtg_bridge_load.sv]
// half-bridge load model that counts shoot-through on its legs
`timescale 1ns/1ps
module dtg_bridge_load import dtg_pkg::*; (
   input wire logic sys_clk_in,
   input wire logic [NUM_PINS-1:0] pwm_in,
   input wire logic [NUM_PAIRS-1:0] indep_in,
   output int shoot_out
);
   initial shoot_out = 0;
   // both switches of a complementary leg on shorts the supply
   always @(posedge sys_clk_in) begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
         if (!indep_in[p] && pwm_in[2*p] && pwm_in[2*p+1]) begin
            shoot_out <= shoot_out + 1;
         end
      end
   end
endmodule

// [bench/dtg_deadtime_tb.sv]
// self-checking bench for the dead-time and pair-mode block
`timescale 1ns/1ps
module dtg_deadtime_tb import dtg_pkg::*;;
   logic sys_clk_in, rst_n_in, rd_d, ph_on, rst_q, gap_on, pw1_d;
   dtg_bus_s bus_in;
   logic [NUM_PAIRS-1:0] duty_cmp_in, indep;
   logic [NUM_PAIRS*2-1:0] duty_lsb_in;
   dtg_rsp_s rsp_out;
   logic [NUM_PINS-1:0] pwm_out;
   dtg_phase_e phase_out;
   logic [3:0] ph_exp;
   logic [7:0] m, s, v, rd_q[$];
   logic [7:0] rst_v[7] = '{DEADTIME_CONFIG_RST, OUTPUT_PAIR_CONFIG_RST,
      OVERRIDE_ENABLE_MASK_RST, OVERRIDE_STATE_RST, TIMEBASE_CTRL_RST, 8'h00, 8'h00};
   logic [7:0] wm[7] = '{8'hFF, 8'h07, 8'h3F, 8'h3F, 8'h07, 8'h00, 8'h00};
   int mismatches, comparisons, cycles, shoots, gcnt, rises, seed, n, dv, glo_q[$], ghi_q[$];
   dtg_deadtime dtg_deadtime_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .bus_in(bus_in), .duty_cmp_in(duty_cmp_in), .duty_lsb_in(duty_lsb_in),
      .rsp_out(rsp_out), .pwm_out(pwm_out), .phase_out(phase_out));
   dtg_bridge_load dtg_bridge_load_inst (.sys_clk_in(sys_clk_in), .pwm_in(pwm_out),
      .indep_in(indep), .shoot_out(shoots));
   initial begin
      sys_clk_in = 1'b0;
      forever #25 sys_clk_in = ~sys_clk_in;
   end
   task automatic finish_test();
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk_val(input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (e !== g) begin
         mismatches++;
         $display("unexpected value at %0t: expected %0h got %0h", $time, e, g);
      end
   endtask
   task automatic chk_gap(input int lo, input int hi, input int g);
      comparisons++;
      if (g < lo || g > hi) begin
         mismatches++;
         $display("unexpected gap at %0t: expected %0h..%0h got %0h", $time, lo, hi, g);
      end
   endtask
   function automatic logic [7:0] pins(input logic [2:0] c);
      return {2'b00, {2{c[2]}}, {2{c[1]}}, {2{c[0]}}};
   endfunction
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk_in);
      bus_in.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge sys_clk_in);
      rd_q.push_back(e);
      bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk_in);
      bus_in.rd <= 1'b0;
   endtask
   task automatic settle();
      repeat (4) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
   endtask
   // watcher: read data, phase rotation, dead-time gaps on pair 0
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles > 30000) begin
         mismatches++;
         finish_test();
      end
      rd_d <= bus_in.rd;
      if (rd_d && rd_q.size() > 0) chk_val(rd_q.pop_front(), rsp_out.rdata);
      if (ph_on) chk_val({4'h0, ph_exp}, {4'h0, phase_out});
      rst_q <= rst_n_in;
      ph_on <= rst_n_in && rst_q;
      ph_exp <= {phase_out[2:0], phase_out[3]};
      pw1_d <= pwm_out[1];
      if (pwm_out[1] && !pw1_d) rises++;
      if (pwm_out[1:0] === 2'b00) begin
         gcnt <= gcnt + 1;
      end else begin
         if (gcnt > 0 && gap_on && glo_q.size() > 0) begin
            chk_gap(glo_q.pop_front(), ghi_q.pop_front(), gcnt);
         end
         gcnt <= 0;
      end
   end
   initial begin
      seed = 32'haaed;
      {rst_n_in, rd_d, ph_on, rst_q, gap_on, pw1_d, ph_exp} = '0;
      {bus_in, duty_cmp_in, duty_lsb_in, indep} = '0;
      {mismatches, comparisons, cycles, gcnt, rises} = '0;
      repeat (8) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      foreach (rst_v[i]) rd(4'(i), rst_v[i]);
      // random writes may force overrides; load told to ignore legs
      indep = 3'b111;
      foreach (wm[i]) begin
         v = 8'($random(seed));
         wr(4'(i), v);
         rd(4'(i), v & wm[i]);
      end
      wr(ADDR_OUTPUT_PAIR_CONFIG, 8'h00);
      wr(ADDR_OVERRIDE_ENABLE_MASK, 8'h3F);
      wr(ADDR_OVERRIDE_STATE, 8'h00);
      repeat (4) @(posedge sys_clk_in);
      indep = 3'b000;
      $display("test registers done");
      gap_on = 1'b1;
      for (int c = 0; c < 8; c++) begin
         n = 1 + ($random(seed) & 7);
         dv = 2 << (c % 4);
         wr(ADDR_TIMEBASE_CTRL, {6'h00, 2'(c / 4)});
         wr(ADDR_DEADTIME_CONFIG, {2'(c % 4), 6'(n)});
         wr(ADDR_TIMEBASE_CTRL, {5'h00, 1'b1, 2'(c / 4)});
         duty_lsb_in <= 6'($random(seed));
         repeat (2) @(posedge sys_clk_in);
         repeat (2) begin
            glo_q.push_back(n * dv - 2);
            ghi_q.push_back(n * dv + dv + 4);
         end
         duty_cmp_in <= 3'b111;
         repeat (3 * n * dv + 8) @(posedge sys_clk_in);
         duty_cmp_in <= 3'b000;
         repeat (3 * n * dv + 8) @(posedge sys_clk_in);
      end
      rd(ADDR_STATUS, 8'h00);
      $display("test dead time done");
      gap_on = 1'b0;
      wr(ADDR_TIMEBASE_CTRL, 8'h01);
      wr(ADDR_DEADTIME_CONFIG, 8'h14);
      wr(ADDR_TIMEBASE_CTRL, 8'h05);
      rises = 0;
      duty_cmp_in <= 3'b111;
      repeat (10) @(posedge sys_clk_in);
      duty_cmp_in <= 3'b000;
      repeat (80) @(posedge sys_clk_in);
      chk_val(8'h00, 8'(rises));
      $display("test short pulse done");
      indep = 3'b111;
      wr(ADDR_OUTPUT_PAIR_CONFIG, 8'h07);
      for (int k = 0; k < 8; k++) begin
         @(posedge sys_clk_in);
         duty_cmp_in <= 3'(k);
         settle();
         chk_val(pins(3'(k)), {2'b00, pwm_out});
      end
      $display("test independent done");
      for (int k = 0; k < 4; k++) begin
         m = 8'($random(seed)) & 8'h3F;
         s = 8'($random(seed)) & 8'h3F;
         wr(ADDR_OVERRIDE_ENABLE_MASK, m);
         wr(ADDR_OVERRIDE_STATE, s);
         duty_cmp_in <= 3'(k + 5);
         settle();
         chk_val((pins(3'(k + 5)) & m) | (s & ~m), {2'b00, pwm_out});
      end
      $display("test override done");
      chk_val(8'h00, 8'(shoots));
      finish_test();
   end
endmodule
